/* File: hdl/scs_pkg.sv */
// Package of constants for the system clock source selector
package scs_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] SYS_CFG_OFS  = 8'h00;  // Clock source select
  localparam logic [7:0] PLL_CFG_OFS  = 8'h04;  // Bypass, divide value, source
  localparam logic [7:0] STATUS_OFS   = 8'h08;  // Active mode, read only

  // ****************************************************************
  // Field layout and widths
  // ****************************************************************
  localparam int DIV_W          = 10;
  localparam int SEL_LSB        = 0;
  localparam int DIV_LSB        = 0;
  localparam int BYPASS_BIT     = 12;
  localparam int OSC_SRC_BIT    = 13;
  localparam int MODE_LSB       = 0;
  localparam int PLL_EN_BIT     = 8;

  // ****************************************************************
  // Reset values and encodings
  // ****************************************************************
  localparam logic [1:0]       SEL_WAKEUP   = 2'h0;
  localparam logic [1:0]       SEL_PLL_PRE  = 2'h2;
  localparam logic [1:0]       SEL_DIRECT   = 2'h3;
  localparam logic [1:0]       SEL_RST      = 2'h0;
  localparam logic             BYPASS_RST   = 1'b1;
  localparam logic             OSC_SRC_RST  = 1'b0;
  localparam logic [DIV_W-1:0] DIV_RST      = 10'h000;

  // Active clock generation method, one-hot
  typedef enum logic [3:0] {
    SCS_MODE_WAKEUP = 4'b0001,
    SCS_MODE_PLL    = 4'b0010,
    SCS_MODE_PRESC  = 4'b0100,
    SCS_MODE_DIRECT = 4'b1000
  } scs_mode_e;

endpackage : scs_pkg

/* File: hdl/scs_prescaler.sv */
// Programmable oscillator prescaler, divide by value plus one
`timescale 1ns/1ps
`default_nettype none

module scs_prescaler #(
  parameter int DIV_W = scs_pkg::DIV_W
) (
  // Clock and reset
  input  wire logic             osc_clk,
  input  wire logic             rst_b,
  // Control from the core domain
  input  wire logic [DIV_W-1:0] div_value,
  // Divided clock
  output logic                  div_clk
);

  // ****************************************************************
  // Reset and control crossing into the oscillator domain
  // ****************************************************************
  logic             rst_s1_q, rst_s2_q;
  logic [DIV_W-1:0] div_s1_q, div_s2_q, div_s3_q;
  logic [DIV_W-1:0] div_use_q;
  logic [DIV_W-1:0] cnt_q;
  logic             half_q;

  // Reset released on the oscillator clock
  always_ff @(posedge osc_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // Divide value crosses as a whole word, so it is synchronised and delayed once more
  always_ff @(posedge osc_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      div_s1_q <= scs_pkg::DIV_RST;
      div_s2_q <= scs_pkg::DIV_RST;
      div_s3_q <= scs_pkg::DIV_RST;
    end else begin
      div_s1_q <= div_value;
      div_s2_q <= div_s1_q;
      div_s3_q <= div_s2_q;
    end
  end

  // Taken only when two successive samples agree: a word caught mid-change never
  // reaches the counter, at the cost of one more oscillator edge of latency
  always_ff @(posedge osc_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      div_use_q <= scs_pkg::DIV_RST;
    end else if (div_s2_q == div_s3_q) begin
      div_use_q <= div_s3_q;
    end
  end

  // ****************************************************************
  // Divider counter
  // ****************************************************************
  // Count 0..value, i.e. value+1 oscillator periods per output period
  always_ff @(posedge osc_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      cnt_q <= '0;
    end else if (cnt_q >= div_use_q) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // High for the first half of the period, so the output is near 50 percent
  always_ff @(posedge osc_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ({1'b0, cnt_q} < (({1'b0, div_use_q} + 1'b1) >> 1));
    end
  end

  // Factor one passes the source straight, keeping its own duty cycle
  assign div_clk = (div_use_q == '0) ? osc_clk : half_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_cnt_bound;
    @(posedge osc_clk) disable iff (!rst_s2_q)
      $stable(div_use_q) |-> (cnt_q <= div_use_q) || ($past(cnt_q) > div_use_q);
  endproperty
  a_cnt_bound : assert property (p_cnt_bound)
    else $error("prescaler count beyond divide value");

  property p_cnt_wrap;
    @(posedge osc_clk) disable iff (!rst_s2_q)
      (cnt_q == div_use_q) && $stable(div_use_q) |=> (cnt_q == '0);
  endproperty
  a_cnt_wrap : assert property (p_cnt_wrap)
    else $error("prescaler did not wrap after divide value");

  // At the top value the count must run all the way; an early wrap caps the factor
  property p_max_div;
    @(posedge osc_clk) disable iff (!rst_s2_q)
      (div_use_q == '1) && $stable(div_use_q) && (cnt_q != '1)
        |=> (cnt_q == $past(cnt_q) + 1'b1);
  endproperty
  a_max_div : assert property (p_max_div)
    else $error("prescaler wrapped early at largest factor");

endmodule : scs_prescaler

`default_nettype wire

/* File: hdl/scs_clock_select.sv */
// System clock source selector with configuration registers
// Summary of operation
// - Select field 11 puts the system clock into direct drive.
// - Direct drive passes the direct clock input unchanged, duty cycle kept.
// - Select 10 with bypass set uses the prescaler on crystal or internal source.
// - Prescaled clock is oscillator frequency over divide value plus one.
// - Divide factor one passes the oscillator unchanged, its duty cycle kept.
// - Largest factor is 1024, the lowest prescaled system frequency.
// - Crystal source with factor one equals direct drive behaviour.
// - Select 10 with bypass clear enables the PLL and uses its clock.
// - Select 00 takes the system clock from the wakeup source.
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module scs_clock_select #(
  parameter int DIV_W = scs_pkg::DIV_W
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Clock sources
  input  wire logic        direct_clock_input,
  input  wire logic        crystal_input_pin,
  input  wire logic        internal_clk_src,
  input  wire logic        wakeup_clk_src,
  input  wire logic        pll_clk,
  // Clock outputs and status
  output logic             pll_enable,
  output logic [3:0]       active_mode,
  output logic             sys_clk
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_s1_q, rst_sync_b;

  // Asserted at once, released two edges after rst_b rises
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q   <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_s1_q   <= 1'b1;
      rst_sync_b <= rst_s1_q;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [1:0]       sel_q;
  logic             bypass_q;
  logic             osc_src_q;
  logic [DIV_W-1:0] div_q;
  logic             wr_sys, wr_pll;

  assign wr_sys = reg_wr && (reg_addr == scs_pkg::SYS_CFG_OFS);
  assign wr_pll = reg_wr && (reg_addr == scs_pkg::PLL_CFG_OFS);

  // Source select field
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sel_q <= scs_pkg::SEL_RST;
    end else if (wr_sys) begin
      sel_q <= reg_wdata[scs_pkg::SEL_LSB +: 2];
    end
  end

  // Bypass, oscillator source and ten bit divide value
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bypass_q  <= scs_pkg::BYPASS_RST;
      osc_src_q <= scs_pkg::OSC_SRC_RST;
      div_q     <= scs_pkg::DIV_RST;
    end else if (wr_pll) begin
      bypass_q  <= reg_wdata[scs_pkg::BYPASS_BIT];
      osc_src_q <= reg_wdata[scs_pkg::OSC_SRC_BIT];
      div_q     <= reg_wdata[scs_pkg::DIV_LSB +: DIV_W];
    end
  end

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  scs_pkg::scs_mode_e mode_d, mode_q;

  // Code 01 is not a generation method; it falls back to the wakeup clock
  always_comb begin
    case (sel_q)
      scs_pkg::SEL_DIRECT:  mode_d = scs_pkg::SCS_MODE_DIRECT;
      scs_pkg::SEL_PLL_PRE: mode_d = bypass_q ? scs_pkg::SCS_MODE_PRESC
                                              : scs_pkg::SCS_MODE_PLL;
      scs_pkg::SEL_WAKEUP:  mode_d = scs_pkg::SCS_MODE_WAKEUP;
      default:              mode_d = scs_pkg::SCS_MODE_WAKEUP;
    endcase
  end

  // Registered mode drives the mux and status; PLL enable is registered from the same decode
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mode_q     <= scs_pkg::SCS_MODE_WAKEUP;
      pll_enable <= 1'b0;
    end else begin
      mode_q     <= mode_d;
      pll_enable <= (mode_d == scs_pkg::SCS_MODE_PLL);
    end
  end

  assign active_mode = mode_q;

  // ****************************************************************
  // Register read
  // ****************************************************************
  // Read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          scs_pkg::SYS_CFG_OFS: reg_rdata[scs_pkg::SEL_LSB +: 2] <= sel_q;
          scs_pkg::PLL_CFG_OFS: begin
            reg_rdata[scs_pkg::DIV_LSB +: DIV_W]  <= div_q;
            reg_rdata[scs_pkg::BYPASS_BIT]        <= bypass_q;
            reg_rdata[scs_pkg::OSC_SRC_BIT]       <= osc_src_q;
          end
          scs_pkg::STATUS_OFS: begin
            reg_rdata[scs_pkg::MODE_LSB +: 4]     <= mode_q;
            reg_rdata[scs_pkg::PLL_EN_BIT]        <= pll_enable;
          end
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Clock path
  // ****************************************************************
  logic osc_clk, presc_clk;

  // Crystal or internal source feeds the prescaler
  assign osc_clk = osc_src_q ? internal_clk_src : crystal_input_pin;

  scs_prescaler #(
    .DIV_W     (DIV_W)
  ) u_presc (
    .osc_clk   (osc_clk),
    .rst_b     (rst_sync_b),
    .div_value (div_q),
    .div_clk   (presc_clk)
  );

  // Plain mux, no reshaping: a switch can glitch, so software changes mode
  // only in settled steps. Crystal with factor one matches direct drive.
  always_comb begin
    case (mode_q)
      scs_pkg::SCS_MODE_DIRECT: sys_clk = direct_clock_input;
      scs_pkg::SCS_MODE_PRESC:  sys_clk = presc_clk;
      scs_pkg::SCS_MODE_PLL:    sys_clk = pll_clk;
      scs_pkg::SCS_MODE_WAKEUP: sys_clk = wakeup_clk_src;
      default:                  sys_clk = wakeup_clk_src;
    endcase
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_direct_sel;
    @(posedge core_clk) disable iff (!rst_sync_b)
      wr_sys && (reg_wdata[1:0] == 2'b11) |-> ##2 (mode_q == scs_pkg::SCS_MODE_DIRECT);
  endproperty
  a_direct_sel : assert property (p_direct_sel)
    else $error("direct drive not entered after select 11");

  property p_direct_pass;
    @(posedge core_clk) disable iff (!rst_sync_b)
      (mode_q == scs_pkg::SCS_MODE_DIRECT) |-> (sys_clk == direct_clock_input);
  endproperty
  a_direct_pass : assert property (p_direct_pass)
    else $error("system clock differs from direct input");

  property p_presc_sel;
    @(posedge core_clk) disable iff (!rst_sync_b)
      (sel_q == 2'b10) && bypass_q |=> (mode_q == scs_pkg::SCS_MODE_PRESC) && !pll_enable;
  endproperty
  a_presc_sel : assert property (p_presc_sel)
    else $error("prescaler mode not entered");

  property p_presc_path;
    @(posedge core_clk) disable iff (!rst_sync_b)
      (mode_q == scs_pkg::SCS_MODE_PRESC) |-> (sys_clk == presc_clk);
  endproperty
  a_presc_path : assert property (p_presc_path)
    else $error("system clock not from prescaler");

  property p_pll_sel;
    @(posedge core_clk) disable iff (!rst_sync_b)
      (sel_q == 2'b10) && !bypass_q |=> pll_enable && (sys_clk == pll_clk);
  endproperty
  a_pll_sel : assert property (p_pll_sel)
    else $error("PLL not enabled or not selected");

  property p_wakeup_sel;
    @(posedge core_clk) disable iff (!rst_sync_b)
      (sel_q == 2'b00) |=> (mode_q == scs_pkg::SCS_MODE_WAKEUP) && (sys_clk == wakeup_clk_src);
  endproperty
  a_wakeup_sel : assert property (p_wakeup_sel)
    else $error("wakeup clock not selected");

  property p_div_read;
    @(posedge core_clk) disable iff (!rst_sync_b)
      wr_pll ##1 (reg_rd && reg_addr == scs_pkg::PLL_CFG_OFS && !reg_wr)
        |=> (reg_rdata[9:0] == $past(reg_wdata[9:0], 2));
  endproperty
  a_div_read : assert property (p_div_read)
    else $error("divide value readback mismatch");

  property p_rd_one;
    @(posedge core_clk) disable iff (!rst_sync_b)
      !reg_rd |=> (reg_rdata == 32'h0000_0000);
  endproperty
  a_rd_one : assert property (p_rd_one)
    else $error("read data stands outside its cycle");

  c_direct : cover property (@(posedge core_clk) mode_q == scs_pkg::SCS_MODE_DIRECT);
  c_presc  : cover property (@(posedge core_clk) mode_q == scs_pkg::SCS_MODE_PRESC);
  c_pll    : cover property (@(posedge core_clk) pll_enable);
  c_maxdiv : cover property (@(posedge core_clk) div_q == 10'h3FF);

endmodule : scs_clock_select

`default_nettype wire

/* File: bench/scs_clk_src_model.sv */
// Free-running clock sources standing outside the selector
`timescale 1ns/1ps
`default_nettype none

module scs_clk_src_model (
  // Oscillator and clock outputs
  output logic xtal_clk,
  output logic int_clk,
  output logic direct_clk,
  output logic wakeup_clk,
  output logic pll_out
);
  // Crystal, 20 ns, uneven duty so reshaping shows
  always begin
    xtal_clk = 1'b0;
    #12;
    xtal_clk = 1'b1;
    #8;
  end

  // Internal source, 200 ns
  always begin
    int_clk = 1'b0;
    #100;
    int_clk = 1'b1;
    #100;
  end

  // Direct input, 30 ns at 30 percent high
  always begin
    direct_clk = 1'b0;
    #21;
    direct_clk = 1'b1;
    #9;
  end

  // Wakeup source, shortened to keep the run brief
  always begin
    wakeup_clk = 1'b0;
    #200;
    wakeup_clk = 1'b1;
    #200;
  end

  // Loop output, 12 ns
  always begin
    pll_out = 1'b0;
    #7;
    pll_out = 1'b1;
    #5;
  end
endmodule // scs_clk_src_model

`default_nettype wire

/* File: bench/scs_clock_select_tb_top.sv */
// Self-checking bench for the system clock source selector
`timescale 1ns/1ps
`default_nettype none

module scs_clock_select_tb_top;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        core_clk;
  logic        rst_b;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  wire  [4:0]  src;
  logic        pll_enable;
  logic [3:0]  active_mode;
  logic        sys_clk;
  int          bad_count;
  int          check_count;
  int          cyc_count;

  // Core clock, 25 ns
  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;

  // Sources: 0 crystal, 1 internal, 2 direct, 3 wakeup, 4 loop
  scs_clk_src_model u_src (
    .xtal_clk   (src[0]),
    .int_clk    (src[1]),
    .direct_clk (src[2]),
    .wakeup_clk (src[3]),
    .pll_out    (src[4])
  );

  scs_clock_select dut (
    .core_clk           (core_clk),
    .rst_b              (rst_b),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_wr             (reg_wr),
    .reg_rd             (reg_rd),
    .reg_rdata          (reg_rdata),
    .direct_clock_input (src[2]),
    .crystal_input_pin  (src[0]),
    .internal_clk_src   (src[1]),
    .wakeup_clk_src     (src[3]),
    .pll_clk            (src[4]),
    .pll_enable         (pll_enable),
    .active_mode        (active_mode),
    .sys_clk            (sys_clk)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    check(reg_rdata, exp);
    @(posedge core_clk);
    #1;
    check(reg_rdata, 32'h0000_0000);
  endtask

  // Write then read back with no gap between the two strobes
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge core_clk);
    reg_rd    <= 1'b0;
    #1;
    check(reg_rdata, exp);
    @(posedge core_clk);
    #1;
    check(reg_rdata, 32'h0000_0000);
  endtask

  // Mode outputs settle two edges after the write strobe
  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic mode(input logic [3:0] m, input logic pe);
    check({27'h0, pll_enable, active_mode}, {27'h0, pe, m});
  endtask

  // Sampled off every source edge so the mux is never caught mid-step
  task automatic follow(input int idx);
    #0.3;
    repeat (500) begin
      #1;
      check({31'h0, sys_clk}, {31'h0, src[idx]});
    end
  endtask

  // A new divide value needs four oscillator edges to land and the switch may
  // clip a period or leave a narrow pulse, so skip five rising edges first
  task automatic per(input logic [31:0] exp);
    realtime t0;
    repeat (5) @(posedge sys_clk);
    t0 = $realtime;
    @(posedge sys_clk);
    check($rtoi($realtime - t0), exp);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(scs_pkg::SYS_CFG_OFS, 32'h0000_0000);
    rd(scs_pkg::PLL_CFG_OFS, 32'h0000_1000);
    rd(scs_pkg::STATUS_OFS, 32'h0000_0001);
    rd(8'h0C, 32'h0000_0000);
    follow(3);
  endtask

  task automatic t_direct();
    wr(scs_pkg::SYS_CFG_OFS, 32'h0000_0003);
    settle();
    mode(scs_pkg::SCS_MODE_DIRECT, 1'b0);
    follow(2);
  endtask

  task automatic t_pll();
    wr(scs_pkg::PLL_CFG_OFS, 32'h0000_0000);
    wr(scs_pkg::SYS_CFG_OFS, 32'h0000_0002);
    settle();
    mode(scs_pkg::SCS_MODE_PLL, 1'b1);
    rd(scs_pkg::STATUS_OFS, 32'h0000_0102);
    follow(4);
  endtask

  task automatic t_presc();
    wr(scs_pkg::PLL_CFG_OFS, 32'h0000_1000);
    settle();
    mode(scs_pkg::SCS_MODE_PRESC, 1'b0);
    repeat (4) @(posedge src[0]);
    follow(0);
    wr(scs_pkg::PLL_CFG_OFS, 32'h0000_1002);
    per(32'd60);
    wr_rd(scs_pkg::PLL_CFG_OFS, 32'h0000_13FF, 32'h0000_13FF);
    per(32'd20480);
    rd(scs_pkg::PLL_CFG_OFS, 32'h0000_13FF);
    wr(scs_pkg::PLL_CFG_OFS, 32'h0000_3004);
    per(32'd1000);
  endtask

  task automatic t_wakeup();
    wr(scs_pkg::SYS_CFG_OFS, 32'h0000_0000);
    settle();
    mode(scs_pkg::SCS_MODE_WAKEUP, 1'b0);
    follow(3);
    // Code 01 is no generation method and falls back to the wakeup clock
    wr(scs_pkg::SYS_CFG_OFS, 32'h0000_0001);
    settle();
    mode(scs_pkg::SCS_MODE_WAKEUP, 1'b0);
    rd(scs_pkg::SYS_CFG_OFS, 32'h0000_0001);
    follow(3);
  endtask

  // ****************************************************************
  // Sequence and watchdog
  // ****************************************************************
  // A stuck divided clock would hang per(), so cap the run
  always @(posedge core_clk) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    rst_b       = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 32'h0000_0000;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    bad_count   = 0;
    check_count = 0;
    cyc_count   = 0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset();
    t_direct();
    t_pll();
    t_presc();
    t_wakeup();
    end_of_test();
  end
endmodule // scs_clock_select_tb_top

`default_nettype wire
